// ==== dcp_consts.vh ====
`ifndef DCP_CONSTS_VH
`define DCP_CONSTS_VH

// instruction byte layout
`define DCP_INS_RW_BIT 7
`define DCP_INS_CNT_HI 6
`define DCP_INS_CNT_LO 5
`define DCP_INS_ADDR_HI 4
`define DCP_INS_ADDR_LO 0

// register map
`define DCP_ADDR_W 5
`define DCP_NUM_REGS 32
`define DCP_CTRL_ADDR 5'h00
`define DCP_CTRL_RESET 8'h80
`define DCP_OTHER_RESET 8'h00
`define DCP_BIT_ORDER_POS 6

// sequencing
`define DCP_BITS_PER_BYTE 4'h8
`define DCP_LAST_BIT 3'h7

`endif

// ==== dcp_regs.v ====
`timescale 1ns/1ns
`include "dcp_consts.vh"

module dcp_regs #(
  parameter NUM_REGS = `DCP_NUM_REGS
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // write port
  input wire i_wr_en,
  input wire [`DCP_ADDR_W-1:0] i_wr_addr,
  input wire [7:0] i_wr_data,
  // read port
  input wire [`DCP_ADDR_W-1:0] i_rd_addr,
  output wire [7:0] o_rd_data,
  // control byte
  output wire [7:0] o_ctrl
);

  reg [7:0] mem_r [0:NUM_REGS-1];
  integer i;

  // every location reads and writes the same way
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (i = 0; i < NUM_REGS; i = i + 1) begin
        mem_r[i] <= (i == 0) ? `DCP_CTRL_RESET : `DCP_OTHER_RESET;
      end
    end else if (i_wr_en) begin
      mem_r[i_wr_addr] <= i_wr_data;
    end
  end

  assign o_rd_data = mem_r[i_rd_addr];
  assign o_ctrl = mem_r[`DCP_CTRL_ADDR];

endmodule

// ==== dcp_port.v ====
`timescale 1ns/1ns
`include "dcp_consts.vh"

module dcp_port (
  // clock and reset
  input wire I_CLK,
  input wire I_RST_N,
  // serial link pins
  input wire I_SCLK,
  input wire I_PORT_SELECT_N,
  input wire I_SDIO,
  output wire O_SDIO,
  output wire O_SDIO_OE,
  input wire I_MODE_RESET,
  // register contents and write activity
  output wire [7:0] O_CTRL,
  output wire O_WR_STB,
  output wire [`DCP_ADDR_W-1:0] O_WR_ADDR,
  output wire [7:0] O_WR_DATA
);

  localparam ST_INSTR = 2'b00;
  localparam ST_DATA = 2'b01;
  localparam ST_DONE = 2'b10;

  // shift one bit into a byte in the chosen order
  function [7:0] shift_in;
    input [7:0] cur;
    input bit_in;
    input lsb_first;
    begin
      shift_in = lsb_first ? {bit_in, cur[7:1]} : {cur[6:0], bit_in};
    end
  endfunction

  // byte address step between data bytes; wraps within the address space
  function [`DCP_ADDR_W-1:0] step_addr;
    input [`DCP_ADDR_W-1:0] cur;
    input lsb_first;
    begin
      step_addr = lsb_first ? cur + {{(`DCP_ADDR_W-1){1'b0}}, 1'b1} :
        cur - {{(`DCP_ADDR_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // read bit that leaves after idx bits of the byte have gone
  function pick_bit;
    input [7:0] data;
    input [2:0] idx;
    input lsb_first;
    begin
      pick_bit = lsb_first ? data[idx] : data[`DCP_LAST_BIT - idx];
    end
  endfunction

  // two-stage synchronisers; the link clock is sampled, not used as a clock
  reg [1:0] sclk_s_r;
  reg [1:0] sel_s_r;
  reg [1:0] sdi_s_r;
  reg [1:0] mode_s_r;
  reg sclk_d_r;
  reg mode_d_r;

  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sclk_s_r <= 2'b00;
      // select resets high so no frame starts out of reset
      sel_s_r <= 2'b11;
      sdi_s_r <= 2'b00;
      mode_s_r <= 2'b00;
      sclk_d_r <= 1'b0;
      mode_d_r <= 1'b0;
    end else begin
      sclk_s_r <= {sclk_s_r[0], I_SCLK};
      sel_s_r <= {sel_s_r[0], I_PORT_SELECT_N};
      sdi_s_r <= {sdi_s_r[0], I_SDIO};
      mode_s_r <= {mode_s_r[0], I_MODE_RESET};
      sclk_d_r <= sclk_s_r[1];
      mode_d_r <= mode_s_r[1];
    end
  end

  wire sclk_rise = sclk_s_r[1] & ~sclk_d_r;
  wire sclk_fall = ~sclk_s_r[1] & sclk_d_r;
  wire sel_n = sel_s_r[1];
  wire sdi = sdi_s_r[1];
  wire mode_fall = mode_d_r & ~mode_s_r[1];
  // restart both when deselected and after a mode/reset pulse
  wire restart = sel_n | mode_fall | mode_s_r[1];

  reg [1:0] state_r;
  reg [2:0] bit_cnt_r;
  reg [7:0] shift_r;
  reg rw_r;
  reg [1:0] left_r;
  reg [`DCP_ADDR_W-1:0] addr_r;
  reg wr_stb_r;
  reg [`DCP_ADDR_W-1:0] wr_addr_r;
  reg [7:0] wr_data_r;
  reg sdo_r;
  reg oe_r;

  wire [7:0] ctrl;
  wire [7:0] rd_data;
  wire lsb_first = ctrl[`DCP_BIT_ORDER_POS];
  wire [7:0] byte_now = shift_in(shift_r, sdi, lsb_first);
  wire byte_end = (bit_cnt_r == `DCP_LAST_BIT);
  // read data may only leave while a read data phase is live
  wire rd_phase = ~restart & (state_r == ST_DATA) & rw_r;

  // one flat array; address 0 also drives the control byte, the other addresses are plain storage
  dcp_regs #(
    .NUM_REGS(`DCP_NUM_REGS)
  ) u_regs (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_wr_en(wr_stb_r),
    .i_wr_addr(wr_addr_r),
    .i_wr_data(wr_data_r),
    .i_rd_addr(addr_r),
    .o_rd_data(rd_data),
    .o_ctrl(ctrl)
  );

  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_r <= ST_INSTR;
      bit_cnt_r <= 3'h0;
      shift_r <= 8'h00;
      rw_r <= 1'b0;
      left_r <= 2'b00;
      addr_r <= {`DCP_ADDR_W{1'b0}};
      wr_stb_r <= 1'b0;
      wr_addr_r <= {`DCP_ADDR_W{1'b0}};
      wr_data_r <= 8'h00;
    end else begin
      wr_stb_r <= 1'b0;
      if (restart) begin
        // a partial byte is simply dropped here
        state_r <= ST_INSTR;
        bit_cnt_r <= 3'h0;
        shift_r <= 8'h00;
      end else if (sclk_rise) begin
        // only the synchronised link clock advances the sequence
        case (state_r)
          ST_INSTR: begin
            shift_r <= byte_now;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (byte_end) begin
              rw_r <= byte_now[`DCP_INS_RW_BIT];
              left_r <= byte_now[`DCP_INS_CNT_HI:`DCP_INS_CNT_LO];
              addr_r <= byte_now[`DCP_INS_ADDR_HI:`DCP_INS_ADDR_LO];
              state_r <= ST_DATA;
            end
          end
          ST_DATA: begin
            shift_r <= byte_now;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (byte_end) begin
              if (!rw_r) begin
                wr_stb_r <= 1'b1;
                wr_addr_r <= addr_r;
                wr_data_r <= byte_now;
              end
              // next address follows the bit order in use
              addr_r <= step_addr(addr_r, lsb_first);
              left_r <= left_r - 2'b01;
              if (left_r == 2'b00) begin
                state_r <= ST_DONE;
              end
            end
          end
          ST_DONE: begin
            // only a restart leaves this state
            state_r <= ST_DONE;
          end
          default: begin
            state_r <= ST_INSTR;
          end
        endcase
      end
    end
  end

  // read data leaves on falling edges, half a link clock ahead of the host's sample
  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sdo_r <= 1'b0;
      oe_r <= 1'b0;
    end else if (!rd_phase) begin
      oe_r <= 1'b0;
    end else if (sclk_fall) begin
      sdo_r <= pick_bit(rd_data, bit_cnt_r, lsb_first);
      oe_r <= 1'b1;
    end
  end

  assign O_SDIO = sdo_r;
  assign O_SDIO_OE = oe_r;
  assign O_CTRL = ctrl;
  assign O_WR_STB = wr_stb_r;
  assign O_WR_ADDR = wr_addr_r;
  assign O_WR_DATA = wr_data_r;

endmodule

// ==== dcp_port_assertions.sv ====
`timescale 1ns/1ns
module dcp_port_assertions (
  input wire I_CLK, I_RST_N, I_SCLK, I_PORT_SELECT_N, I_SDIO, I_MODE_RESET,
  input wire O_SDIO, O_SDIO_OE, O_WR_STB,
  input wire [7:0] O_CTRL, O_WR_DATA,
  input wire [4:0] O_WR_ADDR
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  stb_one_a: assert property (O_WR_STB |=> !O_WR_STB)
    else $error("strobe too long");
  oe_desel_a: assert property (I_PORT_SELECT_N [*5] |-> !O_SDIO_OE)
    else $error("pin driven while deselected");
  wr_desel_a: assert property (I_PORT_SELECT_N [*5] |-> !O_WR_STB)
    else $error("write while deselected");
  wr_mode_a: assert property (I_MODE_RESET [*5] |-> !O_WR_STB)
    else $error("write during mode pulse");
  oe_mode_a: assert property (I_MODE_RESET [*5] |-> !O_SDIO_OE)
    else $error("pin driven during mode pulse");
  wr_hold_a: assert property (!O_WR_STB |-> $stable({O_WR_ADDR, O_WR_DATA}))
    else $error("write fields moved");
  ctrl_upd_a: assert property (O_WR_STB && O_WR_ADDR == 5'h00 |=> O_CTRL == $past(O_WR_DATA))
    else $error("control not updated");
  ctrl_hold_a: assert property (!(O_WR_STB && O_WR_ADDR == 5'h00) |=> $stable(O_CTRL))
    else $error("control moved");
  wr_sel_a: assert property (O_WR_STB |-> !$past(I_PORT_SELECT_N, 4))
    else $error("write without select");
endmodule
bind dcp_port dcp_port_assertions chk_u (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_SCLK(I_SCLK),
  .I_PORT_SELECT_N(I_PORT_SELECT_N), .I_SDIO(I_SDIO), .I_MODE_RESET(I_MODE_RESET),
  .O_SDIO(O_SDIO), .O_SDIO_OE(O_SDIO_OE), .O_WR_STB(O_WR_STB), .O_CTRL(O_CTRL),
  .O_WR_DATA(O_WR_DATA), .O_WR_ADDR(O_WR_ADDR));

// ==== dcp_host_model.sv ====
`timescale 1ns/1ns
module dcp_host_model (
  input wire clk,
  input wire sdio,
  output reg sclk,
  output reg sel_n,
  output reg sdo,
  output reg mode
);
  reg lsb;
  reg [7:0] b;
  initial {sclk, sel_n, sdo, mode, lsb} = 5'b01000;
  task half;
    repeat (4) @(negedge clk);
  endtask
  // released line toggles so a stale level never reads back
  task xbyte(input [7:0] tx, input drv, output [7:0] rx);
    integer i;
    for (i = 0; i < 8; i = i + 1) begin
      sdo = drv ? tx[lsb ? i : 7 - i] : ~sdo;
      half;
      rx[lsb ? i : 7 - i] = sdio;
      sclk = 1;
      half;
      sclk = 0;
    end
  endtask
  task frame(input [7:0] ins, input [31:0] tx, input integer n, output [31:0] rx);
    integer k;
    sel_n = 0;
    half;
    xbyte(ins, 1, b);
    for (k = 0; k < n; k = k + 1) begin
      xbyte(tx[8*(k%4) +: 8], !ins[7], b);
      rx[8*(k%4) +: 8] = b;
    end
    half;
    sel_n = 1;
    half;
  endtask
  // select stays low so the next frame must restart cleanly
  task cut(input [7:0] ins);
    sel_n = 0;
    half;
    xbyte(ins, 1, b);
    sclk = 1;
    half;
    sclk = 0;
    mode = 1;
    half;
    half;
    mode = 0;
    half;
  endtask
endmodule

// ==== tb.sv ====
`timescale 1ns/1ns
module tb;
  reg clk = 0, rst_n = 0;
  wire sclk, sel_n, sdo, mode, o_sdio, oe, stb;
  wire [7:0] ctrl, wdat;
  wire [4:0] wadr;
  wire sdio = oe ? o_sdio : sdo;
  integer err_total = 0, n_tests = 0, i;
  reg [12:0] q[$];
  reg [31:0] d, r;
  reg [4:0] a, x;
  dcp_port dut_u (.I_CLK(clk), .I_RST_N(rst_n), .I_SCLK(sclk), .I_PORT_SELECT_N(sel_n),
    .I_SDIO(sdio), .O_SDIO(o_sdio), .O_SDIO_OE(oe), .I_MODE_RESET(mode), .O_CTRL(ctrl),
    .O_WR_STB(stb), .O_WR_ADDR(wadr), .O_WR_DATA(wdat));
  dcp_host_model h_u (.clk(clk), .sdio(sdio), .sclk(sclk), .sel_n(sel_n), .sdo(sdo),
    .mode(mode));
  initial forever #50 clk = ~clk;
  task automatic chk(input [63:0] nm, input [31:0] e, input [31:0] s);
    n_tests = n_tests + 1;
    if (e !== s) begin
      err_total = err_total + 1;
      $display("Error %s exp %h got %h", nm, e, s);
    end
  endtask
  always @(negedge clk) if (stb === 1'b1) begin
    if (q.size() == 0) chk("wr", 1, 0);
    else chk("wr", q.pop_front(), {wadr, wdat});
  end
  task wr(input [4:0] ad, input [1:0] c, input [31:0] dv, input integer extra);
    integer k;
    for (k = 0; k <= c; k = k + 1) begin
      x = h_u.lsb ? ad + k : ad - k;
      q.push_back({x, dv[8*k +: 8]});
    end
    h_u.frame({1'b0, c, ad}, dv, c + 1 + extra, r);
  endtask
  task rd(input [4:0] ad, input [1:0] c, input [31:0] e);
    integer k;
    h_u.frame({1'b1, c, ad}, 0, c + 1, r);
    for (k = 0; k <= c; k = k + 1) chk("rd", e[8*k +: 8], r[8*k +: 8]);
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #2000000;
    err_total = err_total + 1;
    report_and_stop;
  end
  initial begin
    i = $urandom(32'h9700);
    #500 rst_n = 1;
    repeat (4) @(negedge clk);
    chk("ctrl", 8'h80, ctrl);
    rd(5'h00, 0, 32'h80);
    a = 4 + $urandom % 28;
    d = $urandom;
    wr(a, 3, d, 1);
    rd(a, 3, d);
    h_u.cut({3'b000, a});
    wr(a, 0, ~d, 0);
    rd(a, 0, ~d);
    wr(5'h00, 0, 32'hC0, 0);
    h_u.lsb = 1;
    d = $urandom;
    wr(a - 3, 1, d, 0);
    rd(a - 3, 1, d);
    chk("ctrl", 8'hC0, ctrl);
    repeat (8) @(negedge clk);
    chk("queue", 0, q.size());
    @(negedge clk);
    rst_n = 0;
    repeat (5) @(negedge clk);
    rst_n = 1;
    h_u.lsb = 0;
    repeat (4) @(negedge clk);
    chk("ctrl", 8'h80, ctrl);
    rd(a, 0, 0);
    report_and_stop;
  end
endmodule
